// ---- verilog/pmt_pkg.sv ----
// Purpose: Shared constants and types for the period match timer.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes: Offsets are byte addresses inside the timer's window.
package pmt_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_CLEAR = 8'h10;
  localparam logic [7:0] ADDR_ENABLE = 8'h14;
  localparam logic [7:0] ADDR_RUN = 8'h18;

  // Reset values.
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [6:0] CONTROL_RESET = 7'h00;

  // Control field positions.
  localparam int PRE_LSB = 0;
  localparam int ON_BIT = 2;
  localparam int POST_LSB = 3;

  // Clock division: instruction clock is a quarter of the oscillator.
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [3:0] PRE_LAST_1 = 4'h0;
  localparam logic [3:0] PRE_LAST_4 = 4'h3;
  localparam logic [3:0] PRE_LAST_16 = 4'hf;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Time base handed to the PWM units.
  typedef struct packed {
    logic [7:0] count;
    logic match;
  } pmt_timebase_t;

endpackage

// ---- verilog/pmt_timer.sv ----
// Purpose: 8-bit period timer with prescaler, postscaler and AXI4-Lite registers.
// Assumes: aclk is the oscillator; the instruction clock is an enable pulse every 4 cycles.
// Notes: Rules of operation follow, one to a line, tag first.
// Operation
// RL1: Count clock is instruction clock through prescaler.
// RL2: Prescale codes select divide by 1, 4, 16.
// RL3: Postscale ratio equals field value plus one.
// RL4: On bit enables counting; clear holds count.
// RL5: Count up to period, then wrap to zero.
// RL6: Zero period keeps count at zero.
// RL7: Postscaler overflow sets the timer event flag.
// RL8: Raw match pulse goes to serial port.
// RL9: Count or control write clears both scalers.
// RL10: Control write leaves count value unchanged.
// RL11: Reset clears count, sets period all ones.
// RL12: Every reset clears prescaler and postscaler.
// RL13: Count does not increment during sleep.
// RL14: Prescaler keeps partial count across sleep.
// RL15: Control bit seven reads zero, ignores writes.
// RL16: Count and period are readable and writable.
// RL17: Count and match feed the PWM time base.
// RL18: Event flag stays set until software clears.
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module pmt_timer (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device state from the system.
  input wire logic sleep_req,
  // Timer outputs.
  output logic serial_shift_tick,
  output pmt_pkg::pmt_timebase_t pwm_timebase,
  output logic irq
);

  // Register state.
  logic [6:0] control;
  logic [7:0] count;
  logic [7:0] period;
  logic event_flag;
  logic event_enable;
  logic [1:0] instr_div;
  logic [3:0] pre_cnt;
  logic [3:0] post_cnt;
  logic sleep_meta;
  logic sleep_sync;

  // AXI bookkeeping.
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Capture of the sleep level across the clock boundary.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
    end else begin
      sleep_meta <= sleep_req;
      sleep_sync <= sleep_meta;
    end
  end

  // Write channel decode.
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held || aw_take;
  wire have_w = w_held || w_take;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_fire = have_aw && have_w && !s_axi_bvalid;
  wire wr_lane0 = wr_fire && wr_strb[0];
  wire wr_control = wr_lane0 && (wr_addr == pmt_pkg::ADDR_CONTROL);
  wire wr_count = wr_lane0 && (wr_addr == pmt_pkg::ADDR_COUNT);
  wire wr_period = wr_lane0 && (wr_addr == pmt_pkg::ADDR_PERIOD);
  wire wr_clear = wr_lane0 && (wr_addr == pmt_pkg::ADDR_CLEAR) && wr_data[0];
  wire wr_enable = wr_lane0 && (wr_addr == pmt_pkg::ADDR_ENABLE);
  wire wr_run = wr_lane0 && (wr_addr == pmt_pkg::ADDR_RUN);

  // Address check shared by read and write paths.
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == pmt_pkg::ADDR_CONTROL) || (a == pmt_pkg::ADDR_COUNT) ||
                 (a == pmt_pkg::ADDR_PERIOD) || (a == pmt_pkg::ADDR_STATUS) ||
                 (a == pmt_pkg::ADDR_CLEAR) || (a == pmt_pkg::ADDR_ENABLE) ||
                 (a == pmt_pkg::ADDR_RUN);
  endfunction

  // Write address and data hold until both are present, then one response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pmt_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !have_aw && !s_axi_bvalid && !wr_fire;
      s_axi_wready <= !have_w && !s_axi_bvalid && !wr_fire;
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(wr_addr) ? pmt_pkg::RESP_OKAY : pmt_pkg::RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Read data selection; unused upper bits read as zero.
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      pmt_pkg::ADDR_CONTROL: rd_word[7:0] = {1'b0, control}; // see RL15
      pmt_pkg::ADDR_COUNT: rd_word[7:0] = count; // see RL16
      pmt_pkg::ADDR_PERIOD: rd_word[7:0] = period; // see RL16
      pmt_pkg::ADDR_STATUS: rd_word[0] = event_flag;
      pmt_pkg::ADDR_ENABLE: rd_word[0] = event_enable;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel: accept, answer next cycle, hold until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pmt_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= addr_known(s_axi_araddr) ? pmt_pkg::RESP_OKAY : pmt_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Timer stepping decode.
  wire instr_tick = (instr_div == pmt_pkg::INSTR_DIV_LAST); // see RL1
  wire timer_on = control[pmt_pkg::ON_BIT];
  wire [1:0] pre_sel = control[pmt_pkg::PRE_LSB +: 2];
  wire [3:0] post_sel = control[pmt_pkg::POST_LSB +: 4];
  wire [3:0] pre_last = pre_sel[1] ? pmt_pkg::PRE_LAST_16 :
                        (pre_sel[0] ? pmt_pkg::PRE_LAST_4 : pmt_pkg::PRE_LAST_1); // see RL2
  wire run_tick = instr_tick && timer_on && !sleep_sync; // see RL4, RL13, RL14
  wire pre_tick = run_tick && (pre_cnt >= pre_last);
  wire period_match = (count == period);
  wire step_match = pre_tick && period_match; // see RL5, RL6
  wire post_over = step_match && (post_cnt >= post_sel); // see RL3
  wire scaler_clear = wr_count || wr_control; // see RL9

  // Flag clears come from the clear register or a zero written through the run alias.
  wire flag_clear_req = wr_clear || (wr_run && !wr_data[0]); // see RL18
  wire irq_mask = wr_enable ? wr_data[0] : event_enable;
  wire next_irq = (event_flag || post_over) && irq_mask;

  // Instruction clock divider, free running from the oscillator.
  // Writes never clear it, so the first step after a write may come up to three cycles early.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_div <= 2'h0;
    end else begin
      instr_div <= instr_div + 2'h1;
    end
  end

  // Prescaler and postscaler; reset and count or control writes clear both.
  always_ff @(posedge aclk) begin
    if (!aresetn || scaler_clear) begin // see RL12, RL9
      pre_cnt <= 4'h0;
      post_cnt <= 4'h0;
    end else begin
      if (run_tick) begin
        pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
      end
      if (step_match) begin
        post_cnt <= post_over ? 4'h0 : post_cnt + 4'h1; // see RL7
      end
    end
  end

  // Count, period and control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= pmt_pkg::COUNT_RESET; // see RL11
      period <= pmt_pkg::PERIOD_RESET; // see RL11
      control <= pmt_pkg::CONTROL_RESET;
    end else begin
      if (wr_count) begin
        count <= wr_data[7:0]; // see RL16
      end else if (pre_tick) begin
        count <= period_match ? 8'h00 : count + 8'h01; // see RL5, RL6
      end
      if (wr_period) begin
        period <= wr_data[7:0];
      end
      if (wr_control) begin
        control <= wr_data[6:0]; // see RL15, RL10
      end
    end
  end

  // Event flag, enable and interrupt; a new event wins over a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      event_flag <= 1'b0;
      event_enable <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (post_over) begin
        event_flag <= 1'b1; // see RL7, RL18
      end else if (flag_clear_req) begin
        event_flag <= 1'b0; // see RL18
      end
      if (wr_enable) begin
        event_enable <= wr_data[0];
      end
      irq <= next_irq; // see RL7
    end
  end

  // Match pulse and time base for the serial port and PWM units.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_shift_tick <= 1'b0;
      pwm_timebase <= '0;
    end else begin
      serial_shift_tick <= step_match; // see RL8
      pwm_timebase.match <= step_match; // see RL17
      pwm_timebase.count <= count; // see RL17
    end
  end

  // Checks.
  chk_ctl_msb: assert property (@(posedge aclk) disable iff (!aresetn) // see RL15
    s_axi_rvalid && $past(s_axi_araddr) == pmt_pkg::ADDR_CONTROL &&
    $rose(s_axi_rvalid) |-> s_axi_rdata[7] == 1'b0)
    else $error("control bit 7 read as one");
  chk_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn) // see RL5
    step_match && !wr_count |=> count == 8'h00)
    else $error("count did not wrap after match");
  chk_hold_off: assert property (@(posedge aclk) disable iff (!aresetn) // see RL4
    !timer_on && !wr_count |=> $stable(count))
    else $error("count moved while off");
  chk_sleep_hold: assert property (@(posedge aclk) disable iff (!aresetn) // see RL13
    sleep_sync && !wr_count |=> $stable(count))
    else $error("count moved in sleep");
  chk_prescale_keep: assert property (@(posedge aclk) disable iff (!aresetn) // see RL14
    sleep_sync && !scaler_clear |=> $stable(pre_cnt))
    else $error("prescaler changed in sleep");
  chk_scaler_clear: assert property (@(posedge aclk) disable iff (!aresetn) // see RL9
    scaler_clear |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("scalers not cleared by write");
  chk_ctl_keeps: assert property (@(posedge aclk) disable iff (!aresetn) // see RL10
    wr_control && !pre_tick |=> $stable(count))
    else $error("control write changed count");
  chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // see RL18
    event_flag && !flag_clear_req |=> event_flag)
    else $error("event flag dropped by itself");
  chk_zero_period: assert property (@(posedge aclk) disable iff (!aresetn) // see RL6
    period == 8'h00 && count == 8'h00 && !wr_count |=> count == 8'h00)
    else $error("count moved with zero period");
  chk_match_out: assert property (@(posedge aclk) disable iff (!aresetn) // see RL8
    step_match |=> serial_shift_tick && pwm_timebase.match)
    else $error("match pulse not forwarded");
  chk_reset_vals: assert property (@(posedge aclk) // see RL11
    !aresetn |=> count == 8'h00 && period == 8'hff)
    else $error("reset values wrong");

  // Bus answers stand until the master takes them, and writes land as sent.
  chk_axi_bhold: assert property (@(posedge aclk) disable iff (!aresetn) // see RL16
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_axi_rhold: assert property (@(posedge aclk) disable iff (!aresetn) // see RL16
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_period_load: assert property (@(posedge aclk) disable iff (!aresetn) // see RL16
    wr_period |=> period == $past(wr_data[7:0]))
    else $error("period write not stored");
  chk_ctl_load: assert property (@(posedge aclk) disable iff (!aresetn) // see RL15
    wr_control |=> control == $past(wr_data[6:0]))
    else $error("control write not stored");

  // Count stepping and scaler bounds.
  chk_instr_rate: assert property (@(posedge aclk) disable iff (!aresetn) // see RL1
    instr_tick |=> !instr_tick)
    else $error("instruction tick lasted two cycles");
  chk_count_step: assert property (@(posedge aclk) disable iff (!aresetn) // see RL1
    !pre_tick && !wr_count |=> $stable(count))
    else $error("count moved without a prescaled step");
  chk_count_inc: assert property (@(posedge aclk) disable iff (!aresetn) // see RL5
    pre_tick && !period_match && !wr_count |=> count == $past(count) + 8'h01)
    else $error("count did not step by one");
  chk_pre_bound: assert property (@(posedge aclk) disable iff (!aresetn) // see RL2
    pre_cnt <= pre_last)
    else $error("prescaler passed its last count");
  chk_post_bound: assert property (@(posedge aclk) disable iff (!aresetn) // see RL3
    post_cnt <= post_sel)
    else $error("postscaler passed its last count");
  chk_off_prescale: assert property (@(posedge aclk) disable iff (!aresetn) // see RL4
    !timer_on && !scaler_clear |=> $stable(pre_cnt))
    else $error("prescaler moved while off");
  chk_sleep_pipe: assert property (@(posedge aclk) disable iff (!aresetn) // see RL13
    $rose(sleep_sync) |-> $past(sleep_meta))
    else $error("sleep level skipped a stage");
  chk_scaler_reset: assert property (@(posedge aclk) // see RL12
    !aresetn |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
    else $error("scalers not cleared by reset");

  // Event flag, interrupt and forwarded match.
  chk_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // see RL7
    post_over |=> event_flag)
    else $error("postscaler overflow did not set flag");
  chk_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn) // see RL18
    flag_clear_req && !post_over |=> !event_flag)
    else $error("flag not cleared by software");
  chk_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn) // see RL7
    event_flag && event_enable && !wr_enable |=> irq)
    else $error("enabled flag did not raise irq");
  chk_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // see RL7
    !event_flag && !post_over |=> !irq)
    else $error("irq raised without flag");
  chk_shift_once: assert property (@(posedge aclk) disable iff (!aresetn) // see RL8
    serial_shift_tick |=> !serial_shift_tick)
    else $error("shift tick lasted two cycles");
  chk_match_only: assert property (@(posedge aclk) disable iff (!aresetn) // see RL8
    !step_match |=> !serial_shift_tick)
    else $error("shift tick without a match");
  chk_time_base: assert property (@(posedge aclk) disable iff (!aresetn) // see RL17
    1'b1 |=> pwm_timebase.count == $past(count))
    else $error("time base count does not follow count");

endmodule

// ---- test/period_match_timer8_tb.sv ----
// Purpose: Self-checking bench for the period match timer over its AXI4-Lite registers.
// Assumes: Register writes and reads end just after the rising edge that completes them.
// Notes: Tick spacing is measured between match pulses, so the free divider phase drops out.
`timescale 1ns/1ps
module period_match_timer8_tb;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sleep_req, tick, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, e;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  pmt_pkg::pmt_timebase_t tb_out;
  int error_cnt, compares, n, k;
  pmt_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_req(sleep_req), .serial_shift_tick(tick), .pwm_timebase(tb_out), .irq(irq));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, x, s);
    end
  endtask

  // One AXI write; each channel is released when taken, and bready stays up.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic done;
    done = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        done = 1;
      end
    end
  endtask

  // One AXI read; data and response are taken at the handshake edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    logic done;
    done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        v = rdata;
        resp = rresp;
        done = 1;
      end
    end
  endtask

  // Cycles from one match pulse to the next.
  task automatic gap(input logic [7:0] p, output int c);
    c = 0;
    while (tick !== 1'b1) @(posedge aclk);
    do begin
      @(posedge aclk);
      c++;
    end while (tick !== 1'b1);
    chk("pwm_match", tb_out.match, 1);
    chk("pwm_count", tb_out.count, p);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Clock of 8 ns.
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    complete_run;
  end

  // Main sequence.
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_req} = 0;
    {awaddr, araddr, wdata} = 0;
    wstrb = 4'h1;
    error_cnt = 0;
    compares = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pmt_pkg::ADDR_PERIOD, d); chk("period_rst", d, 32'hff);
    rd(pmt_pkg::ADDR_COUNT, d); chk("count_rst", d, 32'h00);
    rd(pmt_pkg::ADDR_STATUS, d); chk("status_rst", d, 32'h00);
    wr(pmt_pkg::ADDR_CONTROL, 32'h80);
    rd(pmt_pkg::ADDR_CONTROL, d); chk("ctrl_bit7", d, 32'h00);
    rd(8'h40, d); chk("unmapped_data", d, 32'h0);
    chk("unmapped_resp", resp, pmt_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1);
    chk("unmapped_bresp", resp, pmt_pkg::RESP_SLVERR);
    // Count load, hold while off, control write keeps count.
    wr(pmt_pkg::ADDR_COUNT, 32'h55);
    rd(pmt_pkg::ADDR_COUNT, d); chk("count_rw", d, 32'h55);
    repeat (50) @(posedge aclk);
    rd(pmt_pkg::ADDR_COUNT, d); chk("count_off", d, 32'h55);
    wr(pmt_pkg::ADDR_CONTROL, 32'h7b);
    rd(pmt_pkg::ADDR_COUNT, d); chk("count_ctrl_wr", d, 32'h55);
    rd(pmt_pkg::ADDR_CONTROL, d); chk("ctrl_rw", d, 32'h7b);
    // Tick spacing is 4 * prescale * (period + 1) for every prescale code.
    wr(pmt_pkg::ADDR_PERIOD, 32'h02);
    chk("bresp_okay", resp, pmt_pkg::RESP_OKAY);
    rd(pmt_pkg::ADDR_PERIOD, d); chk("period_rw", d, 32'h02);
    // A write without byte lane 0 must leave the period alone.
    wstrb <= 4'h0;
    wr(pmt_pkg::ADDR_PERIOD, 32'h77);
    wstrb <= 4'h1;
    rd(pmt_pkg::ADDR_PERIOD, d);
    chk("period_nostrb", d, 32'h02);
    for (k = 0; k < 4; k++) begin
      wr(pmt_pkg::ADDR_CONTROL, 32'h04 | k);
      gap(8'h02, n);
      gap(8'h02, n);
      e = (k == 0) ? 12 : (k == 1) ? 48 : 192;
      chk("tick_gap", n, e);
    end
    // Postscale 1:3 sets the flag on the third match after a control write.
    wr(pmt_pkg::ADDR_CONTROL, 32'h10);
    wr(pmt_pkg::ADDR_COUNT, 32'h00);
    wr(pmt_pkg::ADDR_CLEAR, 32'h1);
    wr(pmt_pkg::ADDR_ENABLE, 32'h1);
    chk("irq_idle", irq, 0);
    wr(pmt_pkg::ADDR_CONTROL, 32'h14);
    n = 0;
    k = 0;
    while (irq !== 1'b1 && k < 200) begin
      @(posedge aclk);
      k++;
      if (tick === 1'b1) n++;
    end
    repeat (3) begin
      @(posedge aclk);
      if (tick === 1'b1) n++;
    end
    chk("post_matches", n, 3);
    repeat (40) @(posedge aclk);
    rd(pmt_pkg::ADDR_STATUS, d); chk("flag_sticky", d, 32'h1);
    wr(pmt_pkg::ADDR_CONTROL, 32'h10);
    wr(pmt_pkg::ADDR_ENABLE, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq_masked", irq, 0);
    wr(pmt_pkg::ADDR_ENABLE, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq_enabled", irq, 1);
    rd(pmt_pkg::ADDR_ENABLE, d);
    chk("enable_rd", d, 32'h1);
    wr(pmt_pkg::ADDR_RUN, 32'h0);
    rd(pmt_pkg::ADDR_STATUS, d); chk("flag_zero_wr", d, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq_cleared", irq, 0);
    // Zero period keeps the count at zero.
    wr(pmt_pkg::ADDR_PERIOD, 32'h00);
    wr(pmt_pkg::ADDR_COUNT, 32'h00);
    wr(pmt_pkg::ADDR_CONTROL, 32'h04);
    repeat (60) @(posedge aclk);
    rd(pmt_pkg::ADDR_COUNT, d); chk("count_zero_period", d, 32'h0);
    // Sleep freezes the count; counting resumes on wake.
    wr(pmt_pkg::ADDR_PERIOD, 32'hff);
    sleep_req <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(pmt_pkg::ADDR_COUNT, e);
    repeat (100) @(posedge aclk);
    rd(pmt_pkg::ADDR_COUNT, d); chk("count_sleep", d, e);
    sleep_req <= 1'b0;
    repeat (100) @(posedge aclk);
    rd(pmt_pkg::ADDR_COUNT, d); chk("count_wake", (d != e), 1);
    // Reset in mid-run restores count and period.
    wr(pmt_pkg::ADDR_PERIOD, 32'h33);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(pmt_pkg::ADDR_PERIOD, d); chk("period_rst2", d, 32'hff);
    rd(pmt_pkg::ADDR_COUNT, d); chk("count_rst2", d, 32'h00);
    complete_run;
  end
endmodule
